// ===== dv/dpsem_host_assertions.sv
`timescale 1ns/100ps
// ****
// write timing on the ram pins
// ****
module dpsem_host_assertions
  import dpsem_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // ram pins
  input dpsem_pins_type ramPins,
  input wire logic [15:0] ramDataOut,
  input wire logic ramDataOe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // short aliases keep the properties readable
  wire logic selOn = !ramPins.chipSelN || !ramPins.flag_select_n;
  wire logic rw = ramPins.rdWrN;
  a_ram_select: assert property (
    !ramPins.chipSelN |-> ramPins.flag_select_n &&
    !(ramPins.upper_byte_enable_n && ramPins.lower_byte_enable_n))
    else $error("bad ram select");
  a_flag_csel: assert property (
    !ramPins.flag_select_n |-> ramPins.chipSelN)
    else $error("flag with select low");
  a_addr_quiet: assert property (
    $changed(ramPins.addr) |-> rw && $past(rw))
    else $error("address moved in write");
  a_no_early_drive: assert property (
    $fell(rw) |-> ramDataOe_n)
    else $error("drive as strobe fell");
  a_drive_window: assert property (
    !ramDataOe_n |-> !rw || !$past(rw))
    else $error("drive outside write");
  a_pulse_width: assert property (
    $fell(rw) |-> !rw [*2])
    else $error("pulse too short");
  a_data_hold: assert property (
    $rose(rw) |-> !ramDataOe_n)
    else $error("data not held");
  a_data_setup: assert property (
    $rose(rw) |-> !$past(ramDataOe_n) && $stable(ramDataOut))
    else $error("data setup short");
  a_addr_setup: assert property (
    $rose(rw) |-> $past(ramPins.addr, 2) == ramPins.addr)
    else $error("address setup short");
  a_enable_span: assert property (
    $rose(rw) |-> $past(selOn, 2) && $past(selOn))
    else $error("enable span short");
  c_ram_write: cover property ($fell(rw) && !ramPins.chipSelN);
  c_flag_write: cover property ($fell(rw) && !ramPins.flag_select_n);
  c_flag_read: cover property (!ramPins.outEnN && !ramPins.flag_select_n);
endmodule

// ===== dv/dpsem_host_tb_top.sv
`timescale 1ns/100ps
`include "dpsem_map.svh"
// ****
// bench for the ram host
// ****
module dpsem_host_tb_top;
  localparam logic [5:0] KWR = 6'h02;
  localparam logic [5:0] KFLG = 6'h04;
  localparam logic [5:0] KBOTH = 6'h18;
  localparam logic [5:0] KLO = 6'h10;
  localparam logic [5:0] KHI = 6'h08;
  localparam logic [5:0] KOE = 6'h20;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, otherOwns = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] ramDataIn, ramDataOut;
  logic ramDataOe_n;
  dpsem_pkg::dpsem_pins_type ramPins;
  int miscompares = 0, n_compared = 0, cycles = 0;
  dpsem_host dut (
    .mclk, .rst_b,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready,
    .ramPins, .ramDataIn, .ramDataOut, .ramDataOe_n
  );
  dpsem_ram_model #(.ACC_NS(8)) farPort (
    .ramPins, .ramDataOut, .ramDataOe_n, .otherOwns, .ramDataIn
  );
  always #5 mclk = ~mclk;
  // a hung handshake ends the run instead of stalling it
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer; sampled settled on the low phase, changed after the edge
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ha, hw, hr;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(negedge mclk);
      ha = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      hw = s_axi_wvalid && s_axi_wready;
      hr = w ? s_axi_bvalid : s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rdat = s_axi_rdata;
      @(posedge mclk);
      s_axi_awvalid <= s_axi_awvalid && !ha;
      s_axi_arvalid <= s_axi_arvalid && !ha;
      s_axi_wvalid <= s_axi_wvalid && !hw;
    end while (!hr);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  // load, start, poll busy down; rdat ends holding status
  task automatic op(input logic [11:0] ad, input logic [15:0] d, input logic [5:0] c);
    axi(1'b1, `DPSEM_ADDR_OFS, {20'h0, ad});
    axi(1'b1, `DPSEM_WDATA_OFS, {16'h0, d});
    axi(1'b1, `DPSEM_CTRL_OFS, {26'h0, c | 6'h01});
    do begin
      axi(1'b0, `DPSEM_STAT_OFS, 32'h0000_0000);
    end while (rdat[0] !== 1'b0);
  endtask
  task automatic t_ram;
    op(12'hfff, 16'ha55a, KWR | KBOTH);
    axi(1'b0, `DPSEM_CTRL_OFS, 32'h0000_0000);
    chk(rdat, {26'h0, KWR | KBOTH});
    op(12'hfff, 16'h0000, KBOTH);
    chk(rdat & 32'hffff_0001, 32'ha55a_0000);
    op(12'hfff, 16'h1234, KWR | KLO | KOE);
    op(12'hfff, 16'h0000, KBOTH);
    chk(rdat & 32'hffff_0001, 32'ha534_0000);
    op(12'hfff, 16'h7799, KWR | KHI);
    op(12'hfff, 16'h0000, KBOTH);
    chk(rdat & 32'hffff_0001, 32'h7734_0000);
    $display("test ram done");
  endtask
  task automatic t_flag;
    op(12'h003, 16'h0000, KFLG);
    chk(rdat & 32'hffff_0003, 32'hffff_0000);
    op(12'h003, 16'h0000, KWR | KFLG);
    op(12'h003, 16'h0000, KFLG);
    chk(rdat & 32'hffff_0003, 32'h0000_0002);
    op(12'h003, 16'h0001, KWR | KFLG);
    op(12'h003, 16'h0000, KFLG);
    chk(rdat & 32'hffff_0003, 32'hffff_0000);
    otherOwns <= 1'b1;
    op(12'h003, 16'h0000, KWR | KFLG);
    op(12'h003, 16'h0000, KFLG);
    chk(rdat & 32'hffff_0003, 32'hffff_0000);
    otherOwns <= 1'b0;
    $display("test flag done");
  endtask
  task automatic t_bus;
    axi(1'b1, `DPSEM_STAT_OFS, 32'hffff_ffff);
    chk({30'h0, rsp}, 32'h0000_0002);
    axi(1'b1, `DPSEM_ADDR_OFS, 32'h0000_0000);
    chk({30'h0, rsp}, 32'h0000_0000);
    axi(1'b0, 4'h2, 32'h0000_0000);
    chk({30'h0, rsp}, 32'h0000_0002);
    chk(rdat, 32'h0000_0000);
    $display("test bus done");
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_bus();
    t_ram();
    t_flag();
    wrap_up();
  end
endmodule
bind dpsem_host dpsem_host_assertions chk_pins (.mclk, .rst_b, .ramPins, .ramDataOut, .ramDataOe_n);

// ===== dv/dpsem_ram_model.sv
`timescale 1ns/100ps
// ****
// one ram port with flags
// ****
module dpsem_ram_model
  import dpsem_pkg::*;
#(
  parameter int ACC_NS = 8
)(
  // pins from the host
  input dpsem_pins_type ramPins,
  input wire logic [15:0] ramDataOut,
  input wire logic ramDataOe_n,
  // far port already holds the flag
  input wire logic otherOwns,
  // data to the host
  output logic [15:0] ramDataIn
);
  logic [15:0] mem [4096];
  logic [7:0] mine = 8'h00;
  logic [15:0] last = 16'h0000;
  wire logic [2:0] fi = ramPins.addr[2:0];
  wire logic flgSel = !ramPins.flag_select_n;
  wire logic ramSel = !ramPins.chipSelN && !flgSel;
  wire logic hiOn = !ramPins.upper_byte_enable_n;
  wire logic loOn = !ramPins.lower_byte_enable_n;
  // an undriven bus shows the inverse of its last value, not a lucky match
  wire logic [15:0] bus = ramDataOe_n ? ~last : ramDataOut;
  wire logic ramWr = ramSel && (hiOn || loOn) && !ramPins.rdWrN;
  wire logic flgWr = flgSel && !ramPins.rdWrN;
  wire logic rdOn = ramPins.rdWrN && !ramPins.outEnN && (ramSel || flgSel);
  wire logic [15:0] val = flgSel ? {16{!mine[fi]}} : mem[ramPins.addr];
  assign #ACC_NS ramDataIn = rdOn ? val : ~last;
  // remember the last driven word
  always @(rdOn or val) begin
    if (rdOn) begin
      last = val;
    end
  end
  // cells take the data held when the overlap closes
  always @(negedge ramWr) begin
    if (hiOn) begin
      mem[ramPins.addr][15:8] = bus[15:8];
    end
    if (loOn) begin
      mem[ramPins.addr][7:0] = bus[7:0];
    end
  end
  // zero requests, one releases; a far side holding it keeps it
  always @(negedge flgWr) begin
    if (bus[0]) begin
      mine[fi] = 1'b0;
    end else if (!otherOwns) begin
      mine[fi] = 1'b1;
    end
  end
endmodule

// ===== hw/dpsem_host.sv
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "dpsem_map.svh"
// Datasheet rules behind this block
// - ram cycle: select low, a byte enable low, flag select high; flag: reverse
// - strobe stays high whenever the address lines change
// - host drives no data while the device may still drive the pins
// - with output enable low, stretch write pulse to release plus data setup
// - write data held at least zero ns after end of write
// - next cycle may start zero ns after the first rising strobe edge
// - write cycle at least 15 ns; enable to end of write at least 12 ns
// - address valid 12 ns before end of write; setup before strobe 0 ns
// - write data stable 10 ns before end of write
// - wait 5 ns after a flag write before reading it, select kept high
// - both ports writing a flag within 5 ns: earlier port wins
module dpsem_host
  import dpsem_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // ram port pins
  output dpsem_pins_type ramPins,
  input wire logic [15:0] ramDataIn,
  output logic [15:0] ramDataOut,
  output logic ramDataOe_n
);

  // ***************************************************
  // software registers
  // ***************************************************
  logic [5:0] ctrl_q;
  logic [11:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic grant_q;
  logic goPulse;
  logic busy;
  logic [3:0] awaddr_q;
  logic [31:0] wbuf_q;
  logic [3:0] wstrb_q;
  logic awHave_q, wHave_q;
  dpsem_state_type state_q;
  logic [2:0] cnt_q;
  logic flagWrote_q;

  // byte-lane merge used for every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign busy = (state_q != ST_IDLE);
  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready = !wHave_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // latch address and data in either order
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awaddr_q <= 4'h0;
      wbuf_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (awHave_q && wHave_q) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wbuf_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // register writes; writes while busy are dropped so pins stay stable
  logic commit;
  logic [31:0] mCtrl, mAddr, mData;
  assign commit = awHave_q && wHave_q;
  assign mCtrl = merge({26'h0, ctrl_q}, wbuf_q, wstrb_q);
  assign mAddr = merge({20'h0, addr_q}, wbuf_q, wstrb_q);
  assign mData = merge({16'h0, wdata_q}, wbuf_q, wstrb_q);
  assign goPulse = commit && !busy && (awaddr_q == `DPSEM_CTRL_OFS)
                   && mCtrl[`DPSEM_CTRL_GO];
  // control bits as the committing write leaves them; ctrl_q only takes them
  // at the same edge as goPulse, so the pins must not read ctrl_q there
  logic goWrite, goFlag, goOeLow, goUpper, goLower;
  assign goWrite = mCtrl[`DPSEM_CTRL_WRITE];
  assign goFlag = mCtrl[`DPSEM_CTRL_FLAG];
  assign goOeLow = mCtrl[`DPSEM_CTRL_OEN];
  assign goUpper = mCtrl[`DPSEM_CTRL_UBE];
  assign goLower = mCtrl[`DPSEM_CTRL_LBE];
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q <= 6'h00;
      addr_q <= 12'h000;
      wdata_q <= 16'h0000;
    end else if (commit && !busy) begin
      unique case (awaddr_q)
        `DPSEM_CTRL_OFS: ctrl_q <= {mCtrl[5:1], 1'b0};
        `DPSEM_ADDR_OFS: addr_q <= mAddr[11:0];
        `DPSEM_WDATA_OFS: wdata_q <= mData[15:0];
        default: ;
      endcase
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == `DPSEM_STAT_OFS || awaddr_q[1:0] != 2'b00) ?
                     2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        `DPSEM_CTRL_OFS: s_axi_rdata <= {26'h0, ctrl_q};
        `DPSEM_ADDR_OFS: s_axi_rdata <= {20'h0, addr_q};
        `DPSEM_WDATA_OFS: s_axi_rdata <= {16'h0, wdata_q};
        `DPSEM_STAT_OFS: s_axi_rdata <= {rdata_q, 14'h0, grant_q, busy};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************************
  // pin sequencer
  // ***************************************************
  logic isWrite, isFlag, oeLow, flagWait;
  logic [2:0] pulseLen;
  assign isWrite = ctrl_q[`DPSEM_CTRL_WRITE];
  assign isFlag = ctrl_q[`DPSEM_CTRL_FLAG];
  assign oeLow = ctrl_q[`DPSEM_CTRL_OEN];
  // a flag read straight after a flag write sits out the write-to-read gap
  assign flagWait = isFlag && flagWrote_q && (cnt_q < 3'(`DPSEM_SWRD_CYC));
  // output enable low means the device may still be driving: pulse covers release plus data setup, still 2 cycles as without it
  assign pulseLen = oeLow ? 3'(`DPSEM_WPOE_CYC) : 3'(`DPSEM_WP_CYC);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'd0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (goPulse) begin
          // flag read right after a flag write waits out the gap first
          state_q <= ST_SETUP;
          cnt_q <= 3'd0;
        end
        ST_SETUP: begin
          if (isWrite) begin
            state_q <= ST_WRPULSE;
            cnt_q <= 3'd1;
          end else if (flagWait) begin
            cnt_q <= cnt_q + 3'd1;
          end else begin
            state_q <= ST_READ;
            cnt_q <= 3'd1;
          end
        end
        ST_WRPULSE: if (cnt_q >= pulseLen) begin
          state_q <= ST_RECOVER;
          cnt_q <= 3'd1;
        end else begin
          cnt_q <= cnt_q + 3'd1;
        end
        ST_READ: if (cnt_q >= 3'(`DPSEM_RD_CYC)) begin
          state_q <= ST_GAP;
        end else begin
          cnt_q <= cnt_q + 3'd1;
        end
        ST_RECOVER: state_q <= ST_IDLE; // data held one cycle past strobe rise
        ST_GAP: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pin drive; address only moves while the strobe is high
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ramPins <= '{chipSelN: 1'b1, upper_byte_enable_n: 1'b1, lower_byte_enable_n: 1'b1,
                   flag_select_n: 1'b1, rdWrN: 1'b1, outEnN: 1'b1, addr: 12'h000};
      ramDataOut <= 16'h0000;
      ramDataOe_n <= 1'b1;
    end else begin
      if (state_q == ST_IDLE && goPulse) begin
        ramPins.addr <= addr_q;
        // flag cycles keep chip select and both byte enables high; a ram cycle
        // with no byte lane chosen leaves the chip deselected, never half-selected
        ramPins.chipSelN <= goFlag | ~(goUpper | goLower);
        ramPins.upper_byte_enable_n <= goFlag | ~goUpper;
        ramPins.lower_byte_enable_n <= goFlag | ~goLower;
        ramPins.flag_select_n <= ~goFlag;
        ramPins.outEnN <= goWrite ? ~goOeLow : 1'b0;
        ramDataOut <= goFlag ? {15'h0, wdata_q[0]} : wdata_q;
      end
      if (state_q == ST_SETUP && isWrite) begin
        ramPins.rdWrN <= 1'b0; // select already low, strobe falls after
      end
      // drive data only once the device has released the pins
      if (state_q == ST_WRPULSE && (!oeLow || cnt_q >= 3'(`DPSEM_WZ_CYC))) begin
        ramDataOe_n <= 1'b0;
      end
      if (state_q == ST_WRPULSE && cnt_q >= pulseLen) begin
        ramPins.rdWrN <= 1'b1;
      end
      if (state_q == ST_RECOVER || state_q == ST_GAP) begin
        ramDataOe_n <= 1'b1;
        ramPins.chipSelN <= 1'b1;
        ramPins.upper_byte_enable_n <= 1'b1;
        ramPins.lower_byte_enable_n <= 1'b1;
        ramPins.flag_select_n <= 1'b1;
        ramPins.outEnN <= 1'b1;
      end
    end
  end

  // read capture and flag ownership
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
      grant_q <= 1'b0;
      flagWrote_q <= 1'b0;
    end else begin
      if (state_q == ST_READ && cnt_q >= 3'(`DPSEM_RD_CYC)) begin
        rdata_q <= ramDataIn;
        // grant follows only flag reads; a ram read leaves it alone
        if (isFlag) begin
          grant_q <= ~ramDataIn[0];
        end
      end
      // a later ram write or any read clears the wait, a flag write sets it, so only flag-to-flag reads pay it
      if (state_q == ST_RECOVER) begin
        flagWrote_q <= isFlag;
      end else if (state_q == ST_GAP) begin
        flagWrote_q <= 1'b0;
      end
    end
  end

endmodule

// ===== hw/dpsem_map.svh
`ifndef DPSEM_MAP_SVH
`define DPSEM_MAP_SVH
// register offsets (byte addresses, one word each)
`define DPSEM_CTRL_OFS 4'h0
`define DPSEM_ADDR_OFS 4'h4
`define DPSEM_WDATA_OFS 4'h8
`define DPSEM_STAT_OFS 4'hC
// control field positions
`define DPSEM_CTRL_GO 0
`define DPSEM_CTRL_WRITE 1
`define DPSEM_CTRL_FLAG 2
`define DPSEM_CTRL_UBE 3
`define DPSEM_CTRL_LBE 4
`define DPSEM_CTRL_OEN 5
// status field positions
`define DPSEM_STAT_BUSY 0
`define DPSEM_STAT_GRANT 1
// pin and clock figures
`define DPSEM_CLK_NS 10
`define DPSEM_TWC_NS 15
`define DPSEM_TEW_NS 12
`define DPSEM_TAW_NS 12
`define DPSEM_TDW_NS 10
`define DPSEM_TWZ_NS 10
`define DPSEM_TSWRD_NS 5
`define DPSEM_TRC_NS 15
`define DPSEM_DHOLD_NS 0
// least times round up to whole cycles
`define DPSEM_CYC(ns) (((ns) + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_WP_CYC `DPSEM_CYC(`DPSEM_TEW_NS)
`define DPSEM_WPOE_CYC `DPSEM_CYC(`DPSEM_TWZ_NS + `DPSEM_TDW_NS)
`define DPSEM_WZ_CYC `DPSEM_CYC(`DPSEM_TWZ_NS)
`define DPSEM_SWRD_CYC `DPSEM_CYC(`DPSEM_TSWRD_NS)
`define DPSEM_RD_CYC `DPSEM_CYC(`DPSEM_TRC_NS)
`define DPSEM_WC_CYC `DPSEM_CYC(`DPSEM_TWC_NS)
`endif

// ===== hw/dpsem_pkg.sv
package dpsem_pkg;
  // pins toward the dual-port ram
  typedef struct packed {
    logic chipSelN;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
    logic flag_select_n;
    logic rdWrN;
    logic outEnN;
    logic [11:0] addr;
  } dpsem_pins_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRPULSE = 3'b010,
    ST_RECOVER = 3'b011,
    ST_READ = 3'b100,
    ST_GAP = 3'b101
  } dpsem_state_type;
endpackage
